// ==== inc/vcu_pkg.sv ====
// How it works
// - target sends its serial data on tx line
// - controller sends serial data on rx line
// - controller raises clear-to-send when it has room
// - target raises request-to-send when ready to receive
// - no data passes unless enable line high
// - four signal lines plus one enable line
// - default 115200 baud, 8 data, no parity, 1 stop
// - default: handshake lines neither paced nor obeyed
// - rate selectable 9600 to 921600, same both ends
// - each flow control line enabled independently
// - controller drops clear-to-send when its buffer is one short of full
// - controller stops sending while request-to-send low
// - target accepts one more character after dropping request
// - controller ignores request line when not obeying it
`default_nettype none
package vcu_pkg;
    // clock and bit rates
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_DEFAULT = 115_200;
    localparam int BAUD_MIN = 9_600;
    localparam int BAUD_MAX = 921_600;
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
    // character framing and buffering
    localparam int DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W = 4;
    localparam logic [LVL_W-1:0] LVL_CTS_LIMIT = 4'h7;
    localparam logic [1:0] RX_SLOTS = 2'h2;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BAUD = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // control bits
    localparam int CTRL_EN = 0;
    localparam int CTRL_RTS_FC = 1;
    localparam int CTRL_CTS_FC = 2;
    // status bits
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_TX_BUSY = 2;
    localparam int ST_OVERRUN = 3;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_CTS = 5;
    localparam int RXD_VALID = 8;
    // bus encodings
    localparam logic OKAY = 1'b0;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {VCU_TX_IDLE, VCU_TX_START, VCU_TX_DATA, VCU_TX_STOP} vcu_tx_st_t;
    typedef enum logic [1:0] {VCU_RX_IDLE, VCU_RX_START, VCU_RX_DATA, VCU_RX_STOP} vcu_rx_st_t;
endpackage : vcu_pkg
`default_nettype wire

// ==== inc/vcu_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface vcu_link_if;
    logic vport_tx_line;
    logic vport_rx_line;
    logic vport_request_to_send;
    logic vport_clear_to_send;
    logic vport_enable_line;
    modport target (output vport_tx_line, output vport_request_to_send,
        output vport_enable_line, input vport_rx_line, input vport_clear_to_send);
    modport board (input vport_tx_line, input vport_request_to_send,
        input vport_enable_line, output vport_rx_line, output vport_clear_to_send);
endinterface : vcu_link_if
`default_nettype wire

// ==== hdl/vcu_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcu_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic [W-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [$clog2(DEPTH+1)-1:0] o_level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] count;
    } vcu_fifo_st_t;
    vcu_fifo_st_t s_r, s_nxt;
    logic push, pop;

    // handshakes straight from the fill count
    assign o_in_ready = (s_r.count != CW'(DEPTH));
    assign o_out_valid = (s_r.count != '0);
    assign o_out_data = s_r.mem[s_r.rptr];
    assign o_level = s_r.count;
    assign push = i_in_valid & o_in_ready;
    assign pop = i_out_ready & o_out_valid;

    // pointer and count update
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wptr] = i_in_data;
            s_nxt.wptr = (s_r.wptr == PW'(DEPTH-1)) ? '0 : PW'(s_r.wptr + 1'b1);
        end
        if (pop) begin
            s_nxt.rptr = (s_r.rptr == PW'(DEPTH-1)) ? '0 : PW'(s_r.rptr + 1'b1);
        end
        if (push && !pop) begin
            s_nxt.count = CW'(s_r.count + 1'b1);
        end else if (pop && !push) begin
            s_nxt.count = CW'(s_r.count - 1'b1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : vcu_fifo
`default_nettype wire

// ==== hdl/vcu_target.sv ====
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vcu_target (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    vcu_link_if.target link
);
    typedef struct packed {
        logic en;
        logic rts_fc;
        logic cts_fc;
        logic [vcu_pkg::DIV_W-1:0] div;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] hrdata;
        vcu_pkg::vcu_tx_st_t tst;
        logic [vcu_pkg::DIV_W-1:0] tcnt;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic txd;
        vcu_pkg::vcu_rx_st_t rst;
        logic [vcu_pkg::DIV_W-1:0] rcnt;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic [1:0][7:0] rbuf;
        logic [1:0] rcount;
        logic ovr;
        logic ferr;
    } vcu_tgt_st_t;
    vcu_tgt_st_t s_r, s_nxt;

    logic acc, stall, is_tx_wr;
    logic tx_in_ready, tx_out_valid, tx_out_ready;
    logic [7:0] tx_out_data;
    logic [31:0] rd_mux;
    logic [vcu_pkg::DIV_W-1:0] wdiv;
    logic rxd, cts;

    assign rxd = link.vport_rx_line;
    assign cts = link.vport_clear_to_send;

    // transmit buffer between the bus and the serializer
    vcu_fifo #(
        .W(8),
        .DEPTH(vcu_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_in_data(i_hwdata[7:0]),
        .i_in_valid(is_tx_wr),
        .o_in_ready(tx_in_ready),
        .o_out_data(tx_out_data),
        .o_out_valid(tx_out_valid),
        .i_out_ready(tx_out_ready),
        .o_level()
    );

    // bus handshake: a full buffer stretches the write data phase
    assign is_tx_wr = s_r.dph_wr & (s_r.dph_addr == vcu_pkg::ADDR_TXDATA);
    assign stall = is_tx_wr & ~tx_in_ready;
    assign acc = i_hsel & i_htrans[1] & i_hready;
    assign o_hreadyout = ~stall;
    assign o_hresp = vcu_pkg::OKAY;
    assign o_hrdata = s_r.hrdata;

    // link outputs
    assign link.vport_tx_line = s_r.txd;
    assign link.vport_enable_line = s_r.en;
    // ready while the two-slot buffer is empty, so one late char fits
    assign link.vport_request_to_send = s_r.rts_fc ? (s_r.en & (s_r.rcount == '0)) : 1'b1;

    // requested divisor kept inside the legal rate range
    always_comb begin
        wdiv = i_hwdata[vcu_pkg::DIV_W-1:0];
        if (wdiv < vcu_pkg::DIV_MIN) begin
            wdiv = vcu_pkg::DIV_MIN;
        end else if (wdiv > vcu_pkg::DIV_MAX) begin
            wdiv = vcu_pkg::DIV_MAX;
        end
    end

    // register read view
    always_comb begin
        rd_mux = vcu_pkg::RD_ZERO;
        unique case (i_haddr[7:0])
            vcu_pkg::ADDR_CTRL: begin
                rd_mux[vcu_pkg::CTRL_EN] = s_r.en;
                rd_mux[vcu_pkg::CTRL_RTS_FC] = s_r.rts_fc;
                rd_mux[vcu_pkg::CTRL_CTS_FC] = s_r.cts_fc;
            end
            vcu_pkg::ADDR_BAUD: rd_mux[vcu_pkg::DIV_W-1:0] = s_r.div;
            vcu_pkg::ADDR_RXDATA: begin
                rd_mux[7:0] = s_r.rbuf[0];
                rd_mux[vcu_pkg::RXD_VALID] = (s_r.rcount != '0);
            end
            vcu_pkg::ADDR_STATUS: begin
                rd_mux[vcu_pkg::ST_RX_AVAIL] = (s_r.rcount != '0);
                rd_mux[vcu_pkg::ST_TX_FULL] = ~tx_in_ready;
                rd_mux[vcu_pkg::ST_TX_BUSY] = (s_r.tst != vcu_pkg::VCU_TX_IDLE) | tx_out_valid;
                rd_mux[vcu_pkg::ST_OVERRUN] = s_r.ovr;
                rd_mux[vcu_pkg::ST_FRAME_ERR] = s_r.ferr;
                rd_mux[vcu_pkg::ST_CTS] = cts;
            end
            default: rd_mux = vcu_pkg::RD_ZERO;
        endcase
    end

    // next state: bus side first, then the serial engines so sets win
    always_comb begin
        s_nxt = s_r;
        tx_out_ready = 1'b0;
        // register writes in the data phase
        if (s_r.dph_wr && !stall) begin
            unique case (s_r.dph_addr)
                vcu_pkg::ADDR_CTRL: begin
                    s_nxt.en = i_hwdata[vcu_pkg::CTRL_EN];
                    s_nxt.rts_fc = i_hwdata[vcu_pkg::CTRL_RTS_FC];
                    s_nxt.cts_fc = i_hwdata[vcu_pkg::CTRL_CTS_FC];
                end
                vcu_pkg::ADDR_BAUD: s_nxt.div = wdiv;
                vcu_pkg::ADDR_STATUS: begin
                    if (i_hwdata[vcu_pkg::ST_OVERRUN]) s_nxt.ovr = 1'b0;
                    if (i_hwdata[vcu_pkg::ST_FRAME_ERR]) s_nxt.ferr = 1'b0;
                end
                default: s_nxt.dph_wr = 1'b0;
            endcase
        end
        // address phase capture; reads answer in the next cycle
        if (!stall) begin
            s_nxt.dph_wr = acc & i_hwrite;
            s_nxt.dph_addr = i_haddr[7:0];
        end
        if (acc && !i_hwrite) begin
            s_nxt.hrdata = rd_mux;
            if (i_haddr[7:0] == vcu_pkg::ADDR_RXDATA && s_r.rcount != '0) begin
                s_nxt.rbuf[0] = s_r.rbuf[1];
                s_nxt.rcount = s_r.rcount - 2'h1;
            end
        end

        // serializer
        unique case (s_r.tst)
            vcu_pkg::VCU_TX_IDLE: begin
                // never start without enable, or while the far end is full if clear-to-send is obeyed
                if (s_r.en && tx_out_valid && (!s_r.cts_fc || cts)) begin
                    tx_out_ready = 1'b1;
                    s_nxt.tsh = tx_out_data;
                    s_nxt.txd = 1'b0;
                    s_nxt.tcnt = s_r.div - vcu_pkg::DIV_ONE;
                    s_nxt.tst = vcu_pkg::VCU_TX_START;
                end
            end
            vcu_pkg::VCU_TX_START: begin
                s_nxt.tcnt = s_r.tcnt - vcu_pkg::DIV_ONE;
                if (s_r.tcnt == '0) begin
                    s_nxt.txd = s_r.tsh[0];
                    s_nxt.tbit = '0;
                    s_nxt.tcnt = s_r.div - vcu_pkg::DIV_ONE;
                    s_nxt.tst = vcu_pkg::VCU_TX_DATA;
                end
            end
            vcu_pkg::VCU_TX_DATA: begin
                s_nxt.tcnt = s_r.tcnt - vcu_pkg::DIV_ONE;
                if (s_r.tcnt == '0) begin
                    s_nxt.tcnt = s_r.div - vcu_pkg::DIV_ONE;
                    if (s_r.tbit == vcu_pkg::LAST_BIT) begin
                        s_nxt.txd = 1'b1;
                        s_nxt.tst = vcu_pkg::VCU_TX_STOP;
                    end else begin
                        s_nxt.tsh = {1'b0, s_r.tsh[7:1]};
                        s_nxt.txd = s_r.tsh[1];
                        s_nxt.tbit = s_r.tbit + 3'h1;
                    end
                end
            end
            vcu_pkg::VCU_TX_STOP: begin
                s_nxt.tcnt = s_r.tcnt - vcu_pkg::DIV_ONE;
                if (s_r.tcnt == '0) s_nxt.tst = vcu_pkg::VCU_TX_IDLE;
            end
        endcase

        // deserializer, sampling mid-bit
        unique case (s_r.rst)
            vcu_pkg::VCU_RX_IDLE: begin
                if (s_r.en && !rxd) begin
                    s_nxt.rcnt = {1'b0, s_r.div[vcu_pkg::DIV_W-1:1]};
                    s_nxt.rst = vcu_pkg::VCU_RX_START;
                end
            end
            vcu_pkg::VCU_RX_START: begin
                s_nxt.rcnt = s_r.rcnt - vcu_pkg::DIV_ONE;
                if (s_r.rcnt == '0) begin
                    s_nxt.rcnt = s_r.div - vcu_pkg::DIV_ONE;
                    s_nxt.rbit = '0;
                    s_nxt.rst = rxd ? vcu_pkg::VCU_RX_IDLE : vcu_pkg::VCU_RX_DATA;
                end
            end
            vcu_pkg::VCU_RX_DATA: begin
                s_nxt.rcnt = s_r.rcnt - vcu_pkg::DIV_ONE;
                if (s_r.rcnt == '0) begin
                    s_nxt.rcnt = s_r.div - vcu_pkg::DIV_ONE;
                    s_nxt.rsh = {rxd, s_r.rsh[7:1]};
                    s_nxt.rbit = s_r.rbit + 3'h1;
                    if (s_r.rbit == vcu_pkg::LAST_BIT) s_nxt.rst = vcu_pkg::VCU_RX_STOP;
                end
            end
            vcu_pkg::VCU_RX_STOP: begin
                s_nxt.rcnt = s_r.rcnt - vcu_pkg::DIV_ONE;
                if (s_r.rcnt == '0) begin
                    s_nxt.rst = vcu_pkg::VCU_RX_IDLE;
                    if (!rxd) begin
                        s_nxt.ferr = 1'b1;
                    end else if (s_nxt.rcount == vcu_pkg::RX_SLOTS) begin
                        s_nxt.ovr = 1'b1;
                    end else begin
                        // late character after request dropped still lands
                        s_nxt.rbuf[s_nxt.rcount[0]] = s_r.rsh;
                        s_nxt.rcount = s_nxt.rcount + 2'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_r <= '0;
            s_r.txd <= 1'b1;
            s_r.div <= vcu_pkg::DIV_DEFAULT;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : vcu_target
`default_nettype wire

// ==== hdl/vcu_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcu_board (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_drive_cts,
    input wire logic i_obey_rts,
    input wire logic [15:0] i_baud_div,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    vcu_link_if.board link
);
    typedef struct packed {
        vcu_pkg::vcu_tx_st_t tst;
        logic [vcu_pkg::DIV_W-1:0] tcnt;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic txd;
        vcu_pkg::vcu_rx_st_t rst;
        logic [vcu_pkg::DIV_W-1:0] rcnt;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic push;
    } vcu_brd_st_t;
    vcu_brd_st_t s_r, s_nxt;
    logic [vcu_pkg::LVL_W-1:0] level;
    logic en, rxd, take;

    assign en = link.vport_enable_line;
    assign rxd = link.vport_tx_line;
    assign link.vport_rx_line = s_r.txd;
    // room left for the character that may already be under way
    assign link.vport_clear_to_send = i_drive_cts ? (level < vcu_pkg::LVL_CTS_LIMIT) : 1'b1;
    // send only when enabled and, if obeyed, the target is ready
    assign o_tx_ready = (s_r.tst == vcu_pkg::VCU_TX_IDLE) & en
        & (!i_obey_rts | link.vport_request_to_send);
    assign take = i_tx_valid & o_tx_ready;

    // input buffer for characters from the target
    vcu_fifo #(
        .W(8),
        .DEPTH(vcu_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_in_data(s_r.rsh),
        .i_in_valid(s_r.push),
        .o_in_ready(),
        .o_out_data(o_rx_data),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_level(level)
    );

    // serial engines at the configured rate
    always_comb begin
        s_nxt = s_r;
        s_nxt.push = 1'b0;
        unique case (s_r.tst)
            vcu_pkg::VCU_TX_IDLE: begin
                if (take) begin
                    s_nxt.tsh = i_tx_data;
                    s_nxt.txd = 1'b0;
                    s_nxt.tcnt = i_baud_div - vcu_pkg::DIV_ONE;
                    s_nxt.tst = vcu_pkg::VCU_TX_START;
                end
            end
            vcu_pkg::VCU_TX_START: begin
                s_nxt.tcnt = s_r.tcnt - vcu_pkg::DIV_ONE;
                if (s_r.tcnt == '0) begin
                    s_nxt.txd = s_r.tsh[0];
                    s_nxt.tbit = '0;
                    s_nxt.tcnt = i_baud_div - vcu_pkg::DIV_ONE;
                    s_nxt.tst = vcu_pkg::VCU_TX_DATA;
                end
            end
            vcu_pkg::VCU_TX_DATA: begin
                s_nxt.tcnt = s_r.tcnt - vcu_pkg::DIV_ONE;
                if (s_r.tcnt == '0) begin
                    s_nxt.tcnt = i_baud_div - vcu_pkg::DIV_ONE;
                    if (s_r.tbit == vcu_pkg::LAST_BIT) begin
                        s_nxt.txd = 1'b1;
                        s_nxt.tst = vcu_pkg::VCU_TX_STOP;
                    end else begin
                        s_nxt.tsh = {1'b0, s_r.tsh[7:1]};
                        s_nxt.txd = s_r.tsh[1];
                        s_nxt.tbit = s_r.tbit + 3'h1;
                    end
                end
            end
            vcu_pkg::VCU_TX_STOP: begin
                s_nxt.tcnt = s_r.tcnt - vcu_pkg::DIV_ONE;
                if (s_r.tcnt == '0) s_nxt.tst = vcu_pkg::VCU_TX_IDLE;
            end
        endcase
        unique case (s_r.rst)
            vcu_pkg::VCU_RX_IDLE: begin
                if (en && !rxd) begin
                    s_nxt.rcnt = {1'b0, i_baud_div[vcu_pkg::DIV_W-1:1]};
                    s_nxt.rst = vcu_pkg::VCU_RX_START;
                end
            end
            vcu_pkg::VCU_RX_START: begin
                s_nxt.rcnt = s_r.rcnt - vcu_pkg::DIV_ONE;
                if (s_r.rcnt == '0) begin
                    s_nxt.rcnt = i_baud_div - vcu_pkg::DIV_ONE;
                    s_nxt.rbit = '0;
                    s_nxt.rst = rxd ? vcu_pkg::VCU_RX_IDLE : vcu_pkg::VCU_RX_DATA;
                end
            end
            vcu_pkg::VCU_RX_DATA: begin
                s_nxt.rcnt = s_r.rcnt - vcu_pkg::DIV_ONE;
                if (s_r.rcnt == '0) begin
                    s_nxt.rcnt = i_baud_div - vcu_pkg::DIV_ONE;
                    s_nxt.rsh = {rxd, s_r.rsh[7:1]};
                    s_nxt.rbit = s_r.rbit + 3'h1;
                    if (s_r.rbit == vcu_pkg::LAST_BIT) s_nxt.rst = vcu_pkg::VCU_RX_STOP;
                end
            end
            vcu_pkg::VCU_RX_STOP: begin
                s_nxt.rcnt = s_r.rcnt - vcu_pkg::DIV_ONE;
                if (s_r.rcnt == '0) begin
                    s_nxt.rst = vcu_pkg::VCU_RX_IDLE;
                    s_nxt.push = rxd; // bad stop bit drops the character
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_r <= '0;
            s_r.txd <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : vcu_board
`default_nettype wire

// ==== sim/vcu_link_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module vcu_link_props #(
    parameter int DIV = 135
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic vport_tx_line,
    input wire logic vport_rx_line,
    input wire logic vport_request_to_send,
    input wire logic vport_clear_to_send,
    input wire logic vport_enable_line
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [1:0] ln_q;
    logic [1:0] busy;
    int cnt [2];
    wire logic [1:0] ln = {vport_rx_line, vport_tx_line};
    // cycles since the start edge of the frame on each line
    always_ff @(posedge i_ref_clk) begin
        ln_q <= ln;
        for (int k = 0; k < 2; k++) begin
            if (!i_rst_n) begin
                busy[k] <= 1'h0;
                cnt[k] <= 0;
            end else if (busy[k]) begin
                busy[k] <= cnt[k] < 10 * DIV - 1;
                cnt[k] <= cnt[k] + 1;
            end else if (ln_q[k] && !ln[k]) begin
                busy[k] <= 1'h1;
                cnt[k] <= 1;
            end
        end
    end
    // a frame begins with a fall of an idle line
    sequence s_tx_begin;
        !busy[0] ##0 $fell(vport_tx_line);
    endsequence
    sequence s_rx_begin;
        !busy[1] ##0 $fell(vport_rx_line);
    endsequence
    property p_tx_start; busy[0] && cnt[0] < DIV |-> !vport_tx_line; endproperty
    a_tx_start: assert property (p_tx_start) else $error("tx start bit not low");
    property p_tx_stop; busy[0] && cnt[0] >= 9 * DIV |-> vport_tx_line; endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("tx stop bit not high");
    property p_tx_hold; busy[0] && cnt[0] % DIV != 0 |-> $stable(vport_tx_line); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx bit changed mid bit");
    property p_rx_start; busy[1] && cnt[1] < DIV |-> !vport_rx_line; endproperty
    a_rx_start: assert property (p_rx_start) else $error("rx start bit not low");
    property p_rx_stop; busy[1] && cnt[1] >= 9 * DIV |-> vport_rx_line; endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("rx stop bit not high");
    property p_tx_en; s_tx_begin |-> vport_enable_line; endproperty
    a_tx_en: assert property (p_tx_en) else $error("tx frame while disabled");
    property p_rx_en; s_rx_begin |-> vport_enable_line; endproperty
    a_rx_en: assert property (p_rx_en) else $error("rx frame while disabled");
    property p_idle_rst;
        $rose(i_rst_n) |-> vport_tx_line && vport_rx_line && !vport_enable_line;
    endproperty
    a_idle_rst: assert property (p_idle_rst) else $error("lines not idle after reset");
endmodule : vcu_link_props
`default_nettype wire

// ==== sim/virtual_com_uart_link_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
        num_errors++; \
        $display("mismatch %s exp %h got %h", nm, ex, got); \
    end \
end
module virtual_com_uart_link_tb;
    localparam int DIV = 135;
    localparam int LIM = 40000;
    localparam logic [7:0] A_CTL = vcu_pkg::ADDR_CTRL;
    localparam logic [7:0] A_BAUD = vcu_pkg::ADDR_BAUD;
    localparam logic [7:0] A_TX = vcu_pkg::ADDR_TXDATA;
    localparam logic [7:0] A_RX = vcu_pkg::ADDR_RXDATA;
    localparam logic [7:0] A_ST = vcu_pkg::ADDR_STATUS;
    logic i_ref_clk = 1'h0, i_rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, v;
    logic cts_en = 1'h0, obey = 1'h0, btx_v = 1'h0, brx_rdy = 1'h0;
    logic [15:0] bdiv = 16'h0087;
    logic [7:0] btx_d = 8'h00;
    logic [7:0] pat [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
    wire logic [31:0] hrdata;
    wire logic hready, hresp, btx_rdy, brx_v;
    wire logic [7:0] brx_d;
    int num_errors = 0, total_checks = 0;
    vcu_link_if link ();
    vcu_target vcu_target_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .link(link));
    vcu_board vcu_board_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_drive_cts(cts_en),
        .i_obey_rts(obey), .i_baud_div(bdiv), .i_tx_data(btx_d), .i_tx_valid(btx_v),
        .o_tx_ready(btx_rdy), .o_rx_data(brx_d), .o_rx_valid(brx_v), .i_rx_ready(brx_rdy),
        .link(link));
    vcu_link_props #(.DIV(DIV)) vcu_link_props_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .vport_tx_line(link.vport_tx_line), .vport_rx_line(link.vport_rx_line),
        .vport_request_to_send(link.vport_request_to_send),
        .vport_clear_to_send(link.vport_clear_to_send),
        .vport_enable_line(link.vport_enable_line));
    // 125 MHz clock
    initial forever #4 i_ref_clk = ~i_ref_clk;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    function automatic logic sig(input int k);
        return k == 0 ? hready : (k == 1 ? btx_rdy : brx_v);
    endfunction : sig
    // bounded wait for an edge that samples the chosen handshake high
    task automatic await(input int k);
        int n;
        n = 0;
        do begin @(posedge i_ref_clk); n++; end while (sig(k) !== 1'h1 && n < LIM);
        if (sig(k) !== 1'h1) begin num_errors++; tally_and_finish(); end
    endtask : await
    // one single word transfer, read data lands in v
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        await(0);
        htrans <= 2'h0;
        hwdata <= wd;
        await(0);
        v = hrdata;
        `CHK("hresp", vcu_pkg::OKAY, hresp)
    endtask : bus
    task automatic bsend(input logic [7:0] d);
        btx_d <= d;
        btx_v <= 1'h1;
        await(1);
        btx_v <= 1'h0;
        @(posedge i_ref_clk);
    endtask : bsend
    task automatic bpop(input logic [7:0] d);
        await(2);
        `CHK("board rx", d, brx_d)
        brx_rdy <= 1'h1;
        @(posedge i_ref_clk);
        brx_rdy <= 1'h0;
    endtask : bpop
    task automatic trx(input logic [7:0] d);
        int n;
        n = 0;
        do begin bus(1'h0, A_RX, 32'h0000_0000); n++; end while (v[8] !== 1'h1 && n < LIM / 4);
        `CHK("target rx", {23'h00_0000, 1'h1, d}, v)
        if (v[8] !== 1'h1) tally_and_finish();
    endtask : trx
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'h1;
        @(posedge i_ref_clk);
        // reset values, unmapped place, divisor clamp
        bus(1'h0, A_CTL, 32'h0000_0000);
        `CHK("ctrl", 32'h0000_0000, v)
        bus(1'h0, A_BAUD, 32'h0000_0000);
        `CHK("baud", {16'h0000, vcu_pkg::DIV_DEFAULT}, v)
        bus(1'h0, A_ST, 32'h0000_0000);
        `CHK("status", 32'h0000_0020, v)
        bus(1'h1, 8'h14, 32'hffff_ffff);
        bus(1'h0, 8'h14, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, v)
        bus(1'h1, A_BAUD, 32'h0000_0001);
        bus(1'h0, A_BAUD, 32'h0000_0000);
        `CHK("baud lo", {16'h0000, vcu_pkg::DIV_MIN}, v)
        bus(1'h1, A_BAUD, 32'h0000_ffff);
        bus(1'h0, A_BAUD, 32'h0000_0000);
        `CHK("baud hi", {16'h0000, vcu_pkg::DIV_MAX}, v)
        bus(1'h1, A_BAUD, 32'h0000_0087);
        // nothing leaves while the enable line is low
        bus(1'h1, A_TX, 32'h0000_0055);
        repeat (12 * DIV) @(posedge i_ref_clk);
        `CHK("held off", 1'h0, brx_v)
        bus(1'h1, A_CTL, 32'h0000_0001);
        bpop(8'h55);
        // edge patterns both ways
        for (int i = 0; i < 4; i++) bus(1'h1, A_TX, {24'h00_0000, pat[i]});
        for (int i = 0; i < 4; i++) bpop(pat[i]);
        for (int i = 0; i < 4; i++) begin
            bsend(pat[i]);
            trx(pat[i]);
        end
        // flow off: request line ignored, third char overruns
        `CHK("rts idle", 1'h1, link.vport_request_to_send)
        for (int i = 0; i < 3; i++) bsend(pat[i]);
        repeat (12 * DIV) @(posedge i_ref_clk);
        bus(1'h0, A_ST, 32'h0000_0000);
        `CHK("overrun", 1'h1, v[3])
        bus(1'h1, A_ST, 32'h0000_0008);
        bus(1'h0, A_ST, 32'h0000_0000);
        `CHK("overrun clr", 1'h0, v[3])
        trx(pat[0]);
        trx(pat[1]);
        bus(1'h0, A_RX, 32'h0000_0000);
        `CHK("rx empty", 1'h0, v[8])
        // target paces the board with its request line
        bus(1'h1, A_CTL, 32'h0000_0003);
        obey <= 1'h1;
        @(posedge i_ref_clk);
        `CHK("rts ready", 1'h1, link.vport_request_to_send)
        fork
            for (int i = 1; i < 4; i++) bsend(pat[i]);
        join_none
        repeat (12 * DIV) @(posedge i_ref_clk);
        `CHK("rts held", 1'h0, link.vport_request_to_send)
        for (int i = 1; i < 4; i++) trx(pat[i]);
        bus(1'h0, A_ST, 32'h0000_0000);
        `CHK("no overrun", 1'h0, v[3])
        // board paces the target with clear-to-send, tx buffer fills
        cts_en <= 1'h1;
        bus(1'h1, A_CTL, 32'h0000_0005);
        for (int i = 0; i < 10; i++) bus(1'h1, A_TX, 32'h0000_0010 + i);
        bus(1'h0, A_ST, 32'h0000_0000);
        `CHK("tx full busy", 2'h3, v[2:1])
        repeat (100 * DIV) @(posedge i_ref_clk);
        `CHK("cts low", 1'h0, link.vport_clear_to_send)
        bus(1'h0, A_ST, 32'h0000_0000);
        `CHK("cts busy", 2'h1, {v[5], v[2]})
        for (int i = 0; i < 10; i++) bpop(8'(8'h10 + i));
        tally_and_finish();
    end
endmodule : virtual_com_uart_link_tb
`default_nettype wire
